/* File: hw/serial_rom_boot_sequencer.v */
// ==========================================================
// serial rom boot sequencer
// ==========================================================
// fetches a boot image byte stream and executes it.
// assumes a serial engine that, on o_fetch_go, streams sequential
// bytes from o_fetch_addr into i_rom_valid/i_rom_data until the next
// go, and a register port on the same clock.
//
// How it works
// - instructions are whole words, pointer advances fully
// - top nibble opcode, low nibble option
// - write: address then option+1 data words
// - poll args: address, value, mask, limit, gap
// - poll rereads after gap while mismatched
// - retry limit reached without match halts
// - wait stalls for 24-bit cycle count
// - waits count reference clock edges
// - boot op: third argument byte selects
// - selectors one through six name operations
// - counter load from last two bytes
// - loop: nonzero counter decrements and jumps
// - multi-byte fields assembled high byte first
// - strap 000 waits for cpu; 001 reserved
// - straps 010/011 select i2c 0x51/0x50
// - straps 1xx pick spi pointer offset
// - spi pointer word: settings byte, base
// - pointer bits 5:3 set spi rate
// - pointer bits 7:6 set read type
// - execute until the end instruction
// - hold fetch while boot operation runs
`timescale 1ns/10ps
`include "boot_seq_defines.vh"
module serial_rom_boot_sequencer #(
    parameter FIFO_DEPTH = `FIFO_DEPTH,
    parameter FIFO_AW = `FIFO_AW
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_resetn,
    // straps and reference clock pins
    input wire [2:0] i_boot_mode,
    input wire i_pcie_ref_clock,
    // serial engine control
    output reg o_fetch_go,
    output reg [23:0] o_fetch_addr,
    output reg o_fetch_hold,
    output reg o_use_spi,
    output reg [6:0] o_i2c_dev_addr,
    output reg [2:0] o_spi_rate,
    output reg [1:0] o_spi_mode,
    output reg [7:0] o_spi_read_cmd,
    // byte stream from serial engine
    input wire i_rom_valid,
    input wire [7:0] i_rom_data,
    output wire o_rom_ready,
    // register space
    output reg o_reg_wr,
    output reg o_reg_rd,
    output reg [23:0] o_reg_addr,
    output reg [31:0] o_reg_wdata,
    input wire i_reg_ack,
    input wire [31:0] i_reg_rdata,
    // built-in boot operations
    output reg o_boot_op_start,
    output reg [7:0] o_boot_op_sel,
    input wire i_boot_op_done,
    // status
    output reg o_cpu_boot,
    output reg o_boot_done,
    output reg o_boot_halt,
    output reg o_image_error,
    output reg o_poll_fail
);

// ==========================================================
// states
// ==========================================================
localparam S_RESET = 4'h0;
localparam S_STRAP = 4'h1;
localparam S_START = 4'h2;
localparam S_GATHER = 4'h3;
localparam S_PTR = 4'h4;
localparam S_DISPATCH = 4'h5;
localparam S_WRITE = 4'h6;
localparam S_POLL_VAL = 4'h7;
localparam S_POLL_MASK = 4'h8;
localparam S_POLL_LIM = 4'h9;
localparam S_POLL_RD = 4'ha;
localparam S_WAIT = 4'hb;
localparam S_BOOT = 4'hc;
localparam S_CPU = 4'hd;
localparam S_DONE = 4'he;
localparam S_HALT = 4'hf;

function [7:0] spi_cmd;
    input [1:0] mode;
    begin
        case (mode)
            2'b00: spi_cmd = `SPI_CMD_SINGLE;
            2'b01: spi_cmd = `SPI_CMD_DUAL;
            2'b10: spi_cmd = `SPI_CMD_QUAD;
            default: spi_cmd = `SPI_CMD_FAST;
        endcase
    end
endfunction

function valid_bop;
    input [7:0] sel;
    begin
        valid_bop = (sel >= `BOP_SLICE) && (sel <= `BOP_RECV_FREE);
    end
endfunction

// ==========================================================
// pin synchronisers
// ==========================================================
reg [2:0] mode_s1;
reg [2:0] mode_s2;
reg ref_s1;
reg ref_s2;
reg ref_s3;
wire ref_edge;

always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        mode_s1 <= 3'h0;
        mode_s2 <= 3'h0;
        ref_s1 <= 1'b0;
        ref_s2 <= 1'b0;
        ref_s3 <= 1'b0;
    end else begin
        mode_s1 <= i_boot_mode;
        mode_s2 <= mode_s1;
        ref_s1 <= i_pcie_ref_clock;
        ref_s2 <= ref_s1;
        ref_s3 <= ref_s2;
    end
end

assign ref_edge = ref_s2 && !ref_s3;

// ==========================================================
// byte buffer
// ==========================================================
wire byte_valid;
wire [7:0] byte_data;
wire byte_pop;
reg flush;

byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_flush(flush),
    .i_in_valid(i_rom_valid),
    .i_in_data(i_rom_data),
    .o_in_ready(o_rom_ready),
    .o_out_valid(byte_valid),
    .o_out_data(byte_data),
    .i_out_ready(byte_pop)
);

// ==========================================================
// sequencer
// ==========================================================
reg [3:0] state;
reg [3:0] gather_ret;
reg [1:0] gather_cnt;
reg [31:0] acc;
reg [23:0] pc;
reg [1:0] settle;
reg [3:0] words_left;
reg [31:0] poll_value;
reg [31:0] poll_mask;
reg [15:0] retry_limit;
reg [15:0] retry_gap;
reg [15:0] retry;
reg [23:0] wait_cnt;
reg [3:0] wait_ret;
reg [15:0] loop_cnt [0:1];
reg ptr_phase;
wire [3:0] opcode;
wire [3:0] option;

assign byte_pop = (state == S_GATHER) && byte_valid;
assign opcode = acc[`OP_HI:`OP_LO];
assign option = acc[`OPT_HI:`OPT_LO];

always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        state <= S_RESET;
        gather_ret <= S_DISPATCH;
        gather_cnt <= 2'h0;
        acc <= 32'h00000000;
        pc <= 24'h000000;
        settle <= 2'h0;
        words_left <= 4'h0;
        poll_value <= 32'h00000000;
        poll_mask <= 32'h00000000;
        retry_limit <= 16'h0000;
        retry_gap <= 16'h0000;
        retry <= 16'h0000;
        wait_cnt <= 24'h000000;
        wait_ret <= S_START;
        loop_cnt[0] <= 16'h0000;
        loop_cnt[1] <= 16'h0000;
        ptr_phase <= 1'b0;
        flush <= 1'b0;
        o_fetch_go <= 1'b0;
        o_fetch_addr <= 24'h000000;
        o_fetch_hold <= 1'b0;
        o_use_spi <= 1'b0;
        o_i2c_dev_addr <= 7'h00;
        o_spi_rate <= 3'h0;
        o_spi_mode <= 2'h0;
        o_spi_read_cmd <= `SPI_CMD_SINGLE;
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        o_reg_addr <= 24'h000000;
        o_reg_wdata <= 32'h00000000;
        o_boot_op_start <= 1'b0;
        o_boot_op_sel <= 8'h00;
        o_cpu_boot <= 1'b0;
        o_boot_done <= 1'b0;
        o_boot_halt <= 1'b0;
        o_image_error <= 1'b0;
        o_poll_fail <= 1'b0;
    end else begin
        o_fetch_go <= 1'b0;
        flush <= 1'b0;
        o_boot_op_start <= 1'b0;
        case (state)
            S_RESET: begin
                // let the strap synchroniser fill before sampling
                settle <= settle + 1'b1;
                if (settle == 2'h3) begin
                    state <= S_STRAP;
                end
            end
            S_STRAP: begin
                o_use_spi <= mode_s2[2];
                if (mode_s2 == `STRAP_CPU) begin
                    o_cpu_boot <= 1'b1;
                    state <= S_CPU;
                end else if (mode_s2 == `STRAP_RSVD) begin
                    o_image_error <= 1'b1;
                    o_boot_halt <= 1'b1;
                    state <= S_HALT;
                end else if (!mode_s2[2]) begin
                    o_i2c_dev_addr <= (mode_s2 == `STRAP_I2C_51) ?
                        `I2C_ADDR_A : `I2C_ADDR_B;
                    pc <= `I2C_IMAGE_BASE;
                    state <= S_START;
                end else begin
                    pc <= {20'h00000, mode_s2[1:0], 2'b00};
                    ptr_phase <= 1'b1;
                    state <= S_START;
                end
            end
            S_START: begin
                flush <= 1'b1;
                o_fetch_go <= 1'b1;
                o_fetch_addr <= pc;
                gather_cnt <= 2'h3;
                gather_ret <= ptr_phase ? S_PTR : S_DISPATCH;
                state <= S_GATHER;
            end
            S_GATHER: begin
                if (byte_valid && !flush) begin
                    acc <= {acc[23:0], byte_data};
                    pc <= pc + 24'h000001;
                    gather_cnt <= gather_cnt - 1'b1;
                    if (gather_cnt == 2'h0) begin
                        state <= gather_ret;
                    end
                end
            end
            S_PTR: begin
                ptr_phase <= 1'b0;
                o_spi_rate <= acc[`PTR_RATE_HI:`PTR_RATE_LO];
                o_spi_mode <= acc[`PTR_MODE_HI:`PTR_MODE_LO];
                o_spi_read_cmd <= spi_cmd(acc[`PTR_MODE_HI:`PTR_MODE_LO]);
                pc <= acc[23:0];
                state <= S_START;
            end
            S_DISPATCH: begin
                gather_cnt <= 2'h3;
                gather_ret <= S_DISPATCH;
                case (opcode)
                    `OP_END: begin
                        o_boot_done <= 1'b1;
                        state <= S_DONE;
                    end
                    `OP_WRITE: begin
                        o_reg_addr <= acc[23:0];
                        words_left <= option;
                        gather_ret <= S_WRITE;
                        state <= S_GATHER;
                    end
                    `OP_POLL: begin
                        o_reg_addr <= acc[23:0];
                        gather_ret <= S_POLL_VAL;
                        state <= S_GATHER;
                    end
                    `OP_WAIT: begin
                        wait_cnt <= acc[23:0];
                        wait_ret <= S_GATHER;
                        state <= S_WAIT;
                    end
                    `OP_BOOT: begin
                        o_boot_op_sel <= acc[7:0];
                        if (valid_bop(acc[7:0])) begin
                            o_boot_op_start <= 1'b1;
                            o_fetch_hold <= 1'b1;
                            state <= S_BOOT;
                        end else begin
                            o_image_error <= 1'b1;
                            o_boot_halt <= 1'b1;
                            state <= S_HALT;
                        end
                    end
                    `OP_LOAD: begin
                        loop_cnt[option[0]] <= acc[15:0];
                        state <= S_GATHER;
                    end
                    `OP_LOOP: begin
                        if (loop_cnt[option[0]] != 16'h0000) begin
                            loop_cnt[option[0]] <=
                                loop_cnt[option[0]] - 16'h0001;
                            pc <= acc[23:0];
                            state <= S_START;
                        end else begin
                            state <= S_GATHER;
                        end
                    end
                    default: begin
                        o_image_error <= 1'b1;
                        o_boot_halt <= 1'b1;
                        state <= S_HALT;
                    end
                endcase
            end
            S_WRITE: begin
                o_reg_wr <= 1'b1;
                o_reg_wdata <= acc;
                if (o_reg_wr && i_reg_ack) begin
                    o_reg_wr <= 1'b0;
                    o_reg_addr <= o_reg_addr + 24'h000001;
                    gather_cnt <= 2'h3;
                    if (words_left == 4'h0) begin
                        gather_ret <= S_DISPATCH;
                    end else begin
                        words_left <= words_left - 1'b1;
                        gather_ret <= S_WRITE;
                    end
                    state <= S_GATHER;
                end
            end
            S_POLL_VAL: begin
                poll_value <= acc;
                gather_cnt <= 2'h3;
                gather_ret <= S_POLL_MASK;
                state <= S_GATHER;
            end
            S_POLL_MASK: begin
                poll_mask <= acc;
                gather_cnt <= 2'h3;
                gather_ret <= S_POLL_LIM;
                state <= S_GATHER;
            end
            S_POLL_LIM: begin
                retry_limit <= acc[31:16];
                retry_gap <= acc[15:0];
                retry <= 16'h0000;
                state <= S_POLL_RD;
            end
            S_POLL_RD: begin
                o_reg_rd <= 1'b1;
                if (o_reg_rd && i_reg_ack) begin
                    o_reg_rd <= 1'b0;
                    gather_cnt <= 2'h3;
                    gather_ret <= S_DISPATCH;
                    if ((i_reg_rdata & poll_mask) == poll_value) begin
                        state <= S_GATHER;
                    end else if (retry < retry_limit) begin
                        retry <= retry + 16'h0001;
                        wait_cnt <= {8'h00, retry_gap};
                        wait_ret <= S_POLL_RD;
                        state <= S_WAIT;
                    end else begin
                        o_poll_fail <= 1'b1;
                        o_boot_halt <= 1'b1;
                        state <= S_HALT;
                    end
                end
            end
            S_WAIT: begin
                if (wait_cnt == 24'h000000) begin
                    state <= wait_ret;
                end else if (ref_edge) begin
                    wait_cnt <= wait_cnt - 24'h000001;
                end
            end
            S_BOOT: begin
                if (i_boot_op_done) begin
                    o_fetch_hold <= 1'b0;
                    state <= S_GATHER;
                end
            end
            S_CPU: begin
                state <= S_CPU;
            end
            S_DONE: begin
                state <= S_DONE;
            end
            S_HALT: begin
                state <= S_HALT;
            end
            default: begin
                state <= S_HALT;
            end
        endcase
    end
end

endmodule // serial_rom_boot_sequencer

/* File: hw/boot_seq_defines.vh */
// ==========================================================
// boot sequencer constants
// ==========================================================
// offsets, encodings and field positions shared by the design.
// assumes nothing of its surroundings.
`ifndef BOOT_SEQ_DEFINES_VH
`define BOOT_SEQ_DEFINES_VH

// instruction opcodes, top nibble of the first byte
`define OP_END 4'h0
`define OP_WRITE 4'h1
`define OP_POLL 4'h2
`define OP_WAIT 4'h3
`define OP_BOOT 4'h4
`define OP_LOAD 4'h5
`define OP_LOOP 4'h6

// first word field positions
`define OP_HI 31
`define OP_LO 28
`define OPT_HI 27
`define OPT_LO 24

// strap codes
`define STRAP_CPU 3'h0
`define STRAP_RSVD 3'h1
`define STRAP_I2C_51 3'h2
`define STRAP_I2C_50 3'h3

// i2c device addresses and image offset
`define I2C_ADDR_A 7'h51
`define I2C_ADDR_B 7'h50
`define I2C_IMAGE_BASE 24'h000000

// spi pointer word: offset is 4 times pointer index
`define PTR_STRIDE 2
`define PTR_MODE_HI 31
`define PTR_MODE_LO 30
`define PTR_RATE_HI 29
`define PTR_RATE_LO 27

// spi read commands per mode
`define SPI_CMD_SINGLE 8'h03
`define SPI_CMD_DUAL 8'h3b
`define SPI_CMD_QUAD 8'h6b
`define SPI_CMD_FAST 8'h0b

// built-in boot operation selectors
`define BOP_SLICE 8'h01
`define BOP_REPAIR 8'h02
`define BOP_ALL_FREE 8'h03
`define BOP_ARRAY_FREE 8'h04
`define BOP_HEAD_FREE 8'h05
`define BOP_RECV_FREE 8'h06

// byte buffer between serial engine and sequencer
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

/* File: hw/byte_fifo.v */
// ==========================================================
// byte fifo
// ==========================================================
// flip-flop fifo with valid/ready on both sides and a flush.
// assumes both sides run on the one system clock.
`timescale 1ns/10ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_flush,
    // fill side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    // drain side
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
wire push;
wire pop;

assign o_in_ready = (count != DEPTH[AW:0]);
assign o_out_valid = (count != {(AW+1){1'b0}});
assign o_out_data = mem[rd_ptr];
assign push = i_in_valid && o_in_ready && !i_flush;
assign pop = o_out_valid && i_out_ready && !i_flush;

always @(posedge i_sys_clk) begin
    if (!i_resetn || i_flush) begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_ptr + 1'b1;
        end
        if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
end

always @(posedge i_sys_clk) begin
    if (push) begin
        mem[wr_ptr] <= i_in_data;
    end
end

endmodule // byte_fifo

/* File: tb/serial_rom_boot_sequencer_monitor.sv */
// ==========================================================
// boot sequencer port checker
// ==========================================================
// concurrent checks on the top module ports.
// assumes one system clock and a synchronous low reset.
`timescale 1ns/10ps
module serial_rom_boot_sequencer_monitor (
    // clock and reset
    input wire i_sys_clk,
    input wire i_resetn,
    // inputs watched
    input wire i_boot_op_done,
    input wire i_reg_ack,
    // outputs watched
    input wire o_fetch_go,
    input wire o_fetch_hold,
    input wire o_use_spi,
    input wire [1:0] o_spi_mode,
    input wire [7:0] o_spi_read_cmd,
    input wire o_reg_wr,
    input wire o_reg_rd,
    input wire [23:0] o_reg_addr,
    input wire o_boot_op_start,
    input wire [7:0] o_boot_op_sel,
    input wire o_cpu_boot,
    input wire o_boot_done,
    input wire o_boot_halt,
    input wire o_image_error,
    input wire o_poll_fail
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    property p_hold_no_fetch;
        o_fetch_hold |-> !o_fetch_go;
    endproperty
    a_hold_no_fetch: assert property (p_hold_no_fetch)
        else $error("fetch restarted during boot operation");
    property p_hold_until_done;
        o_fetch_hold && !i_boot_op_done |=> o_fetch_hold;
    endproperty
    a_hold_until_done: assert property (p_hold_until_done)
        else $error("fetch hold dropped before completion");
    property p_op_start;
        o_boot_op_start |-> o_fetch_hold && o_boot_op_sel inside {[1:6]};
    endproperty
    a_op_start: assert property (p_op_start)
        else $error("boot operation started badly");
    property p_halt_quiet;
        o_boot_halt |=> !o_fetch_go && !o_reg_wr && !o_reg_rd
            && !o_boot_op_start;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("activity after halt");
    property p_err_halt;
        $rose(o_image_error) |-> ##[0:1] o_boot_halt;
    endproperty
    a_err_halt: assert property (p_err_halt)
        else $error("image error without halt");
    property p_fail_halt;
        $rose(o_poll_fail) |-> ##[0:1] o_boot_halt;
    endproperty
    a_fail_halt: assert property (p_fail_halt)
        else $error("poll failure without halt");
    property p_req_hold;
        (o_reg_wr || o_reg_rd) && !i_reg_ack |=>
            $stable(o_reg_addr) && (o_reg_wr || o_reg_rd);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("register request changed before ack");
    property p_read_cmd;
        o_boot_done && o_use_spi |-> o_spi_read_cmd ==
            (o_spi_mode == 2'h0 ? 8'h03 : o_spi_mode == 2'h1 ? 8'h3b :
            o_spi_mode == 2'h2 ? 8'h6b : 8'h0b);
    endproperty
    a_read_cmd: assert property (p_read_cmd)
        else $error("read command does not match mode");
    property p_cpu_idle;
        o_cpu_boot |-> !o_fetch_go && !o_reg_wr && !o_reg_rd;
    endproperty
    a_cpu_idle: assert property (p_cpu_idle)
        else $error("fetch or access in cpu boot");
endmodule // serial_rom_boot_sequencer_monitor
bind serial_rom_boot_sequencer serial_rom_boot_sequencer_monitor u_mon (
    .i_sys_clk, .i_resetn, .i_boot_op_done, .i_reg_ack, .o_fetch_go,
    .o_fetch_hold, .o_use_spi, .o_spi_mode, .o_spi_read_cmd, .o_reg_wr,
    .o_reg_rd, .o_reg_addr, .o_boot_op_start, .o_boot_op_sel, .o_cpu_boot,
    .o_boot_done, .o_boot_halt, .o_image_error, .o_poll_fail);

/* File: tb/serial_rom_model.sv */
// ==========================================================
// serial rom and engine model
// ==========================================================
// streams bytes from a go address, optionally every other cycle.
// assumes the bench fills mem before reset is released.
`timescale 1ns/10ps
module serial_rom_model (
    // clock and reset
    input wire i_sys_clk,
    input wire i_resetn,
    // control
    input wire i_fetch_go,
    input wire [23:0] i_fetch_addr,
    input wire i_fetch_hold,
    input wire i_slow,
    // byte stream
    output wire o_valid,
    output wire [7:0] o_data,
    input wire i_ready
);
    logic [7:0] mem [0:255];
    logic [7:0] ptr = 8'h00;
    logic act = 1'b0;
    logic ph = 1'b0;
    assign o_valid = act && !i_fetch_hold && (ph || !i_slow);
    // bytes leave in address order, high byte of a field first
    assign o_data = o_valid ? mem[ptr] : ~mem[ptr];
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            act <= 1'b0;
        end else if (i_fetch_go) begin
            act <= 1'b1;
            ptr <= i_fetch_addr[7:0];
        end else begin
            if (o_valid && i_ready)
                ptr <= ptr + 8'h01;
            ph <= (o_valid && !i_ready) || !ph;
        end
    end
endmodule // serial_rom_model

/* File: tb/serial_rom_boot_sequencer_test.sv */
// ==========================================================
// boot sequencer test
// ==========================================================
// boots images from the rom model under several strap settings.
// assumes the design files and the rom model are compiled first.
`timescale 1ns/10ps
module serial_rom_boot_sequencer_test;
    typedef struct {logic wr; logic [23:0] a; logic [31:0] d;} row_t;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [2:0] i_boot_mode = 3'h0;
    logic i_pcie_ref_clock = 1'b0;
    logic i_reg_ack = 1'b0;
    logic [31:0] i_reg_rdata = 32'h0;
    logic i_boot_op_done = 1'b0;
    logic slow = 1'b0;
    logic full_seen = 1'b0;
    logic [2:0] g = 3'h0;
    wire o_fetch_go, o_fetch_hold, o_use_spi, i_rom_valid, o_rom_ready;
    wire o_reg_wr, o_reg_rd, o_boot_op_start, o_cpu_boot, o_boot_done;
    wire o_boot_halt, o_image_error, o_poll_fail;
    wire [23:0] o_fetch_addr, o_reg_addr;
    wire [6:0] o_i2c_dev_addr;
    wire [2:0] o_spi_rate;
    wire [1:0] o_spi_mode;
    wire [7:0] o_spi_read_cmd, i_rom_data, o_boot_op_sel;
    wire [31:0] o_reg_wdata;
    int error_cnt = 0, tests_run = 0, cycles = 0, k = 0, opc = 0;
    row_t logs[8];
    row_t rows[6] = '{'{1, 24'h040104, 32'h19}, '{1, 24'h040105, 32'h12345678},
        '{1, 24'h10, 32'ha5}, '{1, 24'h10, 32'ha5},
        '{0, 24'h100, 32'h0}, '{0, 24'h100, 32'h15}};
    logic [31:0] img[14] = '{32'h11040104, 32'h19, 32'h12345678, 32'h50000001,
        32'h10000010, 32'ha5, 32'h60000030, 32'h30000004, 32'h40000003,
        32'h20000100, 32'h5, 32'hf, 32'h00020001, 32'h0};
    logic [31:0] pimg[5] = '{32'h20000100, 32'h1, 32'h1, 32'h00010001, 32'h0};
    serial_rom_boot_sequencer dut (.i_sys_clk, .i_resetn, .i_boot_mode,
        .i_pcie_ref_clock, .o_fetch_go, .o_fetch_addr, .o_fetch_hold,
        .o_use_spi, .o_i2c_dev_addr, .o_spi_rate, .o_spi_mode,
        .o_spi_read_cmd, .i_rom_valid, .i_rom_data, .o_rom_ready, .o_reg_wr,
        .o_reg_rd, .o_reg_addr, .o_reg_wdata, .i_reg_ack, .i_reg_rdata,
        .o_boot_op_start, .o_boot_op_sel, .i_boot_op_done, .o_cpu_boot,
        .o_boot_done, .o_boot_halt, .o_image_error, .o_poll_fail);
    serial_rom_model rom (.i_sys_clk, .i_resetn, .i_fetch_go(o_fetch_go),
        .i_fetch_addr(o_fetch_addr), .i_fetch_hold(o_fetch_hold),
        .i_slow(slow), .o_valid(i_rom_valid), .o_data(i_rom_data),
        .i_ready(o_rom_ready));
    always #25 i_sys_clk = ~i_sys_clk;
    always #200 i_pcie_ref_clock = ~i_pcie_ref_clock;
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic put(input int a, input logic [31:0] w);
        for (int i = 0; i < 4; i++)
            rom.mem[a + i] = w[31 - 8 * i -: 8];
    endtask
    task automatic boot(input logic [2:0] m, input logic s);
        @(posedge i_sys_clk);
        i_resetn <= 1'b0;
        i_boot_mode <= m;
        slow <= s;
        repeat (10) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(posedge i_sys_clk);
        #1 chk("reset_cmd", 8'h03, o_spi_read_cmd);
        chk("reset_done", 0, o_boot_done);
        for (int n = 0; n < 4000; n++) begin
            @(posedge i_sys_clk);
            if ((o_boot_done | o_boot_halt | o_cpu_boot) === 1'b1)
                break;
        end
        #1;
    endtask
    // register space answers one cycle after each of the first eight requests
    always @(posedge i_sys_clk) begin
        if ((o_reg_wr | o_reg_rd) === 1'b1 && !i_reg_ack && k < 8) begin
            i_reg_ack <= 1'b1;
            i_reg_rdata <= (k < 6) ? rows[k].d : 32'h0;
            logs[k] <= '{o_reg_wr, o_reg_addr, o_reg_wdata};
            k <= k + 1;
        end else
            i_reg_ack <= 1'b0;
    end
    // boot operation completes 30 cycles after start
    always @(posedge i_sys_clk) begin
        if (o_boot_op_start === 1'b1)
            opc <= 1;
        else if (opc != 0 && opc < 31)
            opc <= opc + 1;
        i_boot_op_done <= (opc == 30);
        if (opc == 25) begin
            chk("op_sel", 8'h03, o_boot_op_sel);
            chk("op_hold", 1, o_fetch_hold);
        end
        if (o_fetch_go === 1'b1) begin
            g[0] <= g[0] | (o_fetch_addr == 24'h4);
            g[1] <= g[1] | (o_fetch_addr == 24'h20);
            g[2] <= g[2] | (o_fetch_addr == 24'h30);
        end
        if (i_rom_valid && o_rom_ready === 1'b0)
            full_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        #1;
        put(4, 32'ha8000020);
        foreach (img[i])
            put(32 + 4 * i, img[i]);
        boot(3'h5, 1'b1);
        for (int i = 0; i < 6; i++) begin
            chk("reg_kind", rows[i].wr, logs[i].wr);
            chk("reg_addr", rows[i].a, logs[i].a);
            if (rows[i].wr)
                chk("reg_data", rows[i].d, logs[i].d);
        end
        chk("done", 1, o_boot_done & ~o_boot_halt);
        chk("spi_rate", 5, o_spi_rate);
        chk("spi_mode", 2, o_spi_mode);
        chk("spi_cmd", 8'h6b, o_spi_read_cmd);
        chk("use_spi", 1, o_use_spi);
        chk("jumps", 3'h7, g);
        chk("fifo_full", 1, full_seen);
        chk("poll_ok", 6, k);
        put(0, 32'h70000000);
        boot(3'h2, 1'b0);
        chk("i2c_a", 7'h51, o_i2c_dev_addr);
        chk("i2c_bus", 0, o_use_spi);
        chk("bad_op", 1, o_image_error & o_boot_halt);
        foreach (pimg[i])
            put(4 * i, pimg[i]);
        boot(3'h3, 1'b0);
        chk("i2c_b", 7'h50, o_i2c_dev_addr);
        chk("poll_fail", 1, o_poll_fail & o_boot_halt);
        chk("poll_reads", 8, k);
        chk("fail_done", 0, o_boot_done);
        boot(3'h1, 1'b0);
        chk("reserved", 1, o_image_error & o_boot_halt);
        boot(3'h0, 1'b0);
        repeat (20) @(posedge i_sys_clk);
        chk("cpu_boot", 1, o_cpu_boot);
        chk("cpu_idle", 8, k);
        end_of_test();
    end
endmodule // serial_rom_boot_sequencer_test
